/* src/sprt_core.sv */
// serial host port with data-ready flag timing
`timescale 1ns/100ps
// Operation
// - ready high at least 280/N or 560/N clocks
// - first read after update raises ready flag
// - repeat reads return same previous result
// - output data changes on falling serial clock, on rising with idle-low clock
// - input data sampled on rising serial clock, on falling with idle-low clock
module sprt_core #(
    parameter int unsigned RESULT_W = sprt_pkg::RESULT_WIDTH,
    parameter int unsigned CMD_W = sprt_pkg::CMD_WIDTH
) (
    // clock and reset
    input wire logic clk,
    input wire logic nrst,
    // serial pins from the host
    input wire logic cs_n,
    input wire logic sclk,
    input wire logic sdi,
    // serial data pin toward the host
    output logic sdo,
    output logic sdo_oe,
    // active-low data-ready flag
    output logic ready_n,
    // filter rate and doubler settings
    input wire logic clock_doubler_select,
    input wire logic rate_hi,
    input wire logic rate_lo,
    // conversion output update from the filter
    input wire logic result_valid,
    input wire logic [RESULT_W-1:0] result_data,
    // received command/data bytes
    output logic cmd_valid,
    output logic [CMD_W-1:0] cmd_data,
    // host asks for a result read instead of writing
    input wire logic read_request
);
    // settled copies of the pins
    logic [2:0] pins_sync;
    logic cs_n_s;
    logic sclk_s;
    logic sdi_s;

    sprt_sync #(
        .WIDTH(3)
    ) u_sync (
        .clk(clk),
        .nrst(nrst),
        .async_in({cs_n, sclk, sdi}),
        .reset_value(3'h6),
        .sync_out(pins_sync)
    );

    assign cs_n_s = pins_sync[2];
    assign sclk_s = pins_sync[1];
    assign sdi_s = pins_sync[0];

    // edge detection state
    logic sclk_d;
    logic cs_n_d;
    logic next_sclk_d;
    logic next_cs_n_d;
    logic sclk_rise;
    logic sclk_fall;
    logic cs_fall;

    // with an idle-low clock the edge roles swap
    // at frame start; the clock level seen at select picks the mode
    logic idle_low;
    logic next_idle_low;
    logic shift_edge;
    logic sample_edge;

    assign sclk_rise = sclk_s && !sclk_d;
    assign sclk_fall = !sclk_s && sclk_d;
    assign cs_fall = !cs_n_s && cs_n_d;
    // idle-low clock swaps roles, only legal with select toggled
    assign shift_edge = idle_low ? sclk_rise : sclk_fall;
    assign sample_edge = idle_low ? sclk_fall : sclk_rise;

    // transfer state
    sprt_pkg::sprt_xfer_type state;
    sprt_pkg::sprt_xfer_type next_state;
    logic [RESULT_W-1:0] shifter;
    logic [RESULT_W-1:0] next_shifter;
    logic [RESULT_W-1:0] result_hold;
    logic [RESULT_W-1:0] next_result_hold;
    logic [5:0] bit_count;
    logic [5:0] next_bit_count;
    logic next_sdo;
    logic next_sdo_oe;
    logic next_cmd_valid;
    logic [CMD_W-1:0] next_cmd_data;
    logic read_done;

    // ready flag timing
    logic next_ready_n;
    logic [sprt_pkg::HOLD_COUNT_WIDTH-1:0] hold_count;
    logic [sprt_pkg::HOLD_COUNT_WIDTH-1:0] next_hold_count;
    logic [sprt_pkg::HOLD_COUNT_WIDTH-1:0] hold_len;
    logic [1:0] rate_exp;
    // update held back while the high window still runs
    logic pend_valid;
    logic next_pend_valid;
    logic [RESULT_W-1:0] pend_data;
    logic [RESULT_W-1:0] next_pend_data;
    // update released to the result store this cycle
    logic update_take;
    logic [RESULT_W-1:0] update_data;

    // n is 2^(2*hi+lo); shifting the base divides by n
    assign rate_exp = {rate_hi, rate_lo};
    always_comb
    begin
        if (clock_doubler_select)
        begin
            hold_len = sprt_pkg::HOLD_COUNT_WIDTH'(sprt_pkg::READY_HIGH_BASE_X2 >> rate_exp);
        end
        else
        begin
            hold_len = sprt_pkg::HOLD_COUNT_WIDTH'(sprt_pkg::READY_HIGH_BASE >> rate_exp);
        end
    end

    // transfer next-state logic
    always_comb
    begin
        next_sclk_d = sclk_s;
        next_cs_n_d = cs_n_s;
        next_idle_low = idle_low;
        next_state = state;
        next_shifter = shifter;
        next_result_hold = result_hold;
        next_bit_count = bit_count;
        next_sdo = sdo;
        next_sdo_oe = sdo_oe;
        next_cmd_valid = 1'b0;
        next_cmd_data = cmd_data;
        read_done = 1'b0;
        // released update replaces the held result; a deferred one waits
        if (update_take)
        begin
            next_result_hold = update_data;
        end
        if (cs_n_s)
        begin
            // deselected: release the pin and wait
            next_state = sprt_pkg::SPRT_IDLE;
            next_sdo_oe = 1'b0;
            next_bit_count = '0;
        end
        else
        begin
            if (cs_fall)
            begin
                // clock level at select decides polarity
                next_idle_low = !sclk_s;
            end
            case (state)
                sprt_pkg::SPRT_IDLE:
                begin
                    if (read_request)
                    begin
                        // repeat reads reuse the held result
                        next_shifter = result_hold;
                        next_state = sprt_pkg::SPRT_READ;
                    end
                    else
                    begin
                        next_state = sprt_pkg::SPRT_WRITE;
                    end
                    next_bit_count = '0;
                end
                sprt_pkg::SPRT_READ:
                begin
                    if (shift_edge)
                    begin
                        // drive next bit on the shift edge: falling, or rising with an idle-low clock
                        next_sdo = shifter[RESULT_W-1];
                        next_sdo_oe = 1'b1;
                        next_shifter = {shifter[RESULT_W-2:0], 1'b0};
                        next_bit_count = bit_count + 6'h01;
                    end
                    if (sample_edge && bit_count == 6'(RESULT_W))
                    begin
                        // last bit taken by host: read complete
                        read_done = 1'b1;
                        next_state = sprt_pkg::SPRT_IDLE;
                        next_sdo_oe = 1'b0;
                    end
                end
                sprt_pkg::SPRT_WRITE:
                begin
                    if (sample_edge)
                    begin
                        // capture on the sample edge: rising, or falling with an idle-low clock
                        next_shifter = {shifter[RESULT_W-2:0], sdi_s};
                        if (bit_count == 6'(CMD_W - 1))
                        begin
                            next_cmd_valid = 1'b1;
                            next_cmd_data = {shifter[CMD_W-2:0], sdi_s};
                            next_bit_count = '0;
                        end
                        else
                        begin
                            next_bit_count = bit_count + 6'h01;
                        end
                    end
                end
                default:
                begin
                    next_state = sprt_pkg::SPRT_IDLE;
                end
            endcase
        end
    end

    // ready flag next-state: high after first read, low on update
    // an update inside the high window is parked, so the flag never
    // drops early and repeat reads keep seeing the old result
    always_comb
    begin
        next_ready_n = ready_n;
        next_hold_count = hold_count;
        next_pend_valid = pend_valid;
        next_pend_data = pend_data;
        update_take = 1'b0;
        update_data = pend_data;
        if (hold_count != '0)
        begin
            next_hold_count = hold_count - 1'b1;
        end
        if (result_valid)
        begin
            // newest update always wins the parking slot
            next_pend_valid = 1'b1;
            next_pend_data = result_data;
        end
        if (read_done && !ready_n)
        begin
            // first completed read raises the flag and starts the window
            next_ready_n = 1'b1;
            next_hold_count = hold_len;
        end
        else if (hold_count == '0 && (pend_valid || result_valid))
        begin
            // window expired: release the update and lower the flag
            update_take = 1'b1;
            update_data = result_valid ? result_data : pend_data;
            next_pend_valid = 1'b0;
            next_ready_n = 1'b0;
        end
    end

    // registers
    always_ff @(posedge clk)
    begin
        if (!nrst)
        begin
            sclk_d <= 1'b1;
            cs_n_d <= 1'b1;
            idle_low <= 1'b0;
            state <= sprt_pkg::SPRT_IDLE;
            shifter <= '0;
            result_hold <= '0;
            bit_count <= '0;
            sdo <= sprt_pkg::SDO_RESET;
            sdo_oe <= 1'b0;
            cmd_valid <= 1'b0;
            cmd_data <= '0;
            ready_n <= sprt_pkg::READY_N_RESET;
            hold_count <= '0;
            pend_valid <= 1'b0;
            pend_data <= '0;
        end
        else
        begin
            sclk_d <= next_sclk_d;
            cs_n_d <= next_cs_n_d;
            idle_low <= next_idle_low;
            state <= next_state;
            shifter <= next_shifter;
            result_hold <= next_result_hold;
            bit_count <= next_bit_count;
            sdo <= next_sdo;
            sdo_oe <= next_sdo_oe;
            cmd_valid <= next_cmd_valid;
            cmd_data <= next_cmd_data;
            ready_n <= next_ready_n;
            hold_count <= next_hold_count;
            pend_valid <= next_pend_valid;
            pend_data <= next_pend_data;
        end
    end
endmodule : sprt_core

/* src/sprt_pkg.sv */
// shared constants for the serial port ready-timing block
package sprt_pkg;
    // data-ready high time in master clock periods, before division by n
    localparam int unsigned READY_HIGH_BASE = 280;
    localparam int unsigned READY_HIGH_BASE_X2 = 560;
    // widths
    localparam int unsigned RESULT_WIDTH = 24;
    localparam int unsigned CMD_WIDTH = 8;
    localparam int unsigned HOLD_COUNT_WIDTH = 10;
    // reset values
    localparam logic READY_N_RESET = 1'b1;
    localparam logic SDO_RESET = 1'b1;
    // transfer direction
    typedef enum logic [2:0] {
        SPRT_IDLE = 3'b001,
        SPRT_WRITE = 3'b010,
        SPRT_READ = 3'b100
    } sprt_xfer_type;
endpackage : sprt_pkg

/* src/sprt_sync.sv */
// two-stage synchroniser for pin inputs
`timescale 1ns/100ps
module sprt_sync #(
    parameter int unsigned WIDTH = 1
) (
    // clock and reset
    input wire logic clk,
    input wire logic nrst,
    // asynchronous inputs and their settled copies
    input wire logic [WIDTH-1:0] async_in,
    input wire logic [WIDTH-1:0] reset_value,
    output logic [WIDTH-1:0] sync_out
);
    // first stage, read by the second stage only
    logic [WIDTH-1:0] stage1;
    logic [WIDTH-1:0] next_stage1;
    logic [WIDTH-1:0] next_sync_out;

    // next values: reset loads the idle level so no false edge follows
    always_comb
    begin
        if (!nrst)
        begin
            next_stage1 = reset_value;
            next_sync_out = reset_value;
        end
        else
        begin
            next_stage1 = async_in;
            next_sync_out = stage1;
        end
    end

    // register both stages
    always_ff @(posedge clk)
    begin
        stage1 <= next_stage1;
        sync_out <= next_sync_out;
    end
endmodule : sprt_sync

/* test/sprt_core_props.sv */
// concurrent checks on the serial port ready-timing block pins
`timescale 1ns/100ps
module sprt_core_props #(
    parameter int unsigned RESULT_W = 24,
    parameter int unsigned CMD_W = 8
) (
    // clock and reset
    input wire logic clk,
    input wire logic nrst,
    // serial pins
    input wire logic cs_n,
    input wire logic sclk,
    input wire logic sdi,
    input wire logic sdo,
    input wire logic sdo_oe,
    // flag and settings
    input wire logic ready_n,
    input wire logic clock_doubler_select,
    input wire logic rate_hi,
    input wire logic rate_lo,
    // result and command sides
    input wire logic result_valid,
    input wire logic [RESULT_W-1:0] result_data,
    input wire logic cmd_valid,
    input wire logic [CMD_W-1:0] cmd_data,
    input wire logic read_request
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!nrst);
    logic [15:0] high_count; // cycles the flag has been high, saturating
    logic [15:0] next_high_count;
    logic upd_seen; // an update arrived since the flag was last low
    logic [9:0] min_hold; // shortest legal high time for the settings
    assign min_hold = 10'((clock_doubler_select ? sprt_pkg::READY_HIGH_BASE_X2
        : sprt_pkg::READY_HIGH_BASE) >> ({rate_hi, 1'b0} + rate_lo));
    // count high cycles; reset counts as a long high time
    always_comb next_high_count = !ready_n ? 16'h0000 :
        (high_count == 16'hFFFF ? high_count : high_count + 16'h0001);
    always_ff @(posedge clk) high_count <= nrst ? next_high_count : 16'hFFFF;
    // remember updates until the flag has gone low
    always_ff @(posedge clk)
        upd_seen <= !nrst ? 1'b0 : (result_valid ? 1'b1 : (ready_n ? upd_seen : 1'b0));
    // an update lowers the flag once the high window has run out
    sequence s_update;
        ##[1:600] !ready_n;
    endsequence
    // a first read after an update ends by releasing the pin and raising the flag together
    sequence s_read_end;
        $fell(sdo_oe) ##0 $rose(ready_n);
    endsequence
    reset_quiet_a: assert property (disable iff (1'b0)
        !nrst |=> ready_n && !sdo_oe && !cmd_valid) else $error("outputs not idle in reset");
    update_low_a: assert property (result_valid |-> s_update)
        else $error("flag not lowered by update");
    flag_cause_a: assert property ($fell(ready_n) |-> upd_seen)
        else $error("flag lowered without update");
    hold_time_a: assert property ($fell(ready_n) |-> high_count >= 16'(min_hold))
        else $error("flag high time too short");
    read_clear_a: assert property ($rose(ready_n) |-> s_read_end)
        else $error("flag raised outside read end");
    sdo_shift_a: assert property ($past(sdo_oe) && sdo_oe && $changed(sdo)
        |-> !$past(sclk, 2)) else $error("output changed off falling edge");
    oe_frame_a: assert property (sdo_oe |-> !$past(cs_n, 2))
        else $error("pin driven outside frame");
    cmd_edge_a: assert property (cmd_valid |-> $past(sclk, 2) && !$past(cs_n, 2))
        else $error("byte not tied to rising edge");
    cmd_pulse_a: assert property (cmd_valid |=> !cmd_valid)
        else $error("byte strobe longer than a cycle");
endmodule : sprt_core_props
bind sprt_core sprt_core_props #(.RESULT_W(RESULT_W), .CMD_W(CMD_W)) u_props (.clk, .nrst,
    .cs_n, .sclk, .sdi, .sdo, .sdo_oe, .ready_n, .clock_doubler_select, .rate_hi, .rate_lo,
    .result_valid, .result_data, .cmd_valid, .cmd_data, .read_request);

/* test/sprt_host.sv */
// host controller model driving the serial pins
`timescale 1ns/100ps
module sprt_host (
    // system clock
    input wire logic clk,
    // serial pins
    output logic cs_n,
    output logic sclk,
    output logic sdi,
    input wire logic sdo,
    // read or write choice
    output logic read_request
);
    logic [23:0] rx; // bits shifted in, oldest first
    initial
    begin
        cs_n = 1'b1;
        sclk = 1'b1;
        sdi = 1'b0;
        read_request = 1'b0;
        rx = 24'h000000;
    end
    // a released data line keeps toggling so no stale level passes for data
    always @(posedge clk) if (cs_n) sdi <= ~sdi;
    // one 160 ns clock period: data set on fall, both sides sample on rise
    task automatic clk_bit(input logic v);
        sclk <= 1'b0;
        sdi <= v;
        repeat (4) @(posedge clk);
        rx = {rx[22:0], sdo};
        sclk <= 1'b1;
        repeat (4) @(posedge clk);
    endtask : clk_bit
    // frame edges; clock idles high between frames
    task automatic frame(input logic rd, input int n, input logic [7:0] b);
        read_request <= rd;
        cs_n <= 1'b0;
        repeat (4) @(posedge clk);
        for (int i = n - 1; i >= 0; i--) clk_bit(rd ? ~sdi : b[i % 8]);
        repeat (2) @(posedge clk);
        cs_n <= 1'b1;
        repeat (6) @(posedge clk);
    endtask : frame
endmodule : sprt_host

/* test/test_serial_port_ready_timing.sv */
// self-checking bench for the serial port ready-timing block
`timescale 1ns/100ps
`define CHK(n, e, s) begin total_checks++; if ((s) !== (e)) begin \
    $display("MISMATCH %s exp %h seen %h", n, e, s); fail_count++; end end
module test_serial_port_ready_timing;
    logic clk = 1'b0;
    logic nrst = 1'b0;
    logic cs_n, sclk, sdi, sdo, sdo_oe, ready_n, cmd_valid, read_request, oe_q;
    logic clock_doubler_select = 1'b0;
    logic rate_hi = 1'b0;
    logic rate_lo = 1'b0;
    logic result_valid = 1'b0;
    logic [23:0] result_data = 24'h000000;
    logic [7:0] cmd_data, b;
    logic [23:0] d, e;
    logic [23:0] rq[$]; // expected read words
    logic [7:0] cq[$]; // expected written bytes
    int fail_count = 0;
    int total_checks = 0;
    int seed = 41543;
    // master clock stand-in keeps running, also through reset
    // one system cycle stands for one master clock period in range
    always #10 clk = ~clk;
    sprt_core dut (.clk, .nrst, .cs_n, .sclk, .sdi, .sdo, .sdo_oe, .ready_n,
        .clock_doubler_select, .rate_hi, .rate_lo, .result_valid, .result_data,
        .cmd_valid, .cmd_data, .read_request);
    sprt_host host (.clk, .cs_n, .sclk, .sdi, .sdo, .read_request);
    // monitor: each byte strobe or read end takes the oldest note
    always @(posedge clk)
    begin
        if (cmd_valid === 1'b1)
        begin
            e = 24'(cq.pop_front());
            `CHK("cmd_data", e[7:0], cmd_data)
        end
        if (oe_q === 1'b1 && sdo_oe === 1'b0)
        begin
            e = rq.pop_front();
            `CHK("read word", e, host.rx)
            `CHK("ready_n after read", 1'b1, ready_n)
        end
        oe_q <= sdo_oe;
    end
    task automatic conclude();
        $display("checks %0d mismatches %0d", total_checks, fail_count);
        if (fail_count == 0 && total_checks > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask : conclude
    // main sequence: every rate and doubler setting in turn
    initial
    begin
        repeat (16) @(posedge clk);
        nrst <= 1'b1;
        repeat (4) @(posedge clk);
        `CHK("ready_n reset", 1'b1, ready_n)
        `CHK("sdo_oe reset", 1'b0, sdo_oe)
        for (int m = 0; m < 8; m++)
        begin
            {clock_doubler_select, rate_hi, rate_lo} <= 3'(m);
            d = 24'($random(seed));
            b = 8'($random(seed));
            result_data <= d;
            result_valid <= 1'b1;
            @(posedge clk);
            result_valid <= 1'b0;
            repeat (2) @(posedge clk);
            `CHK("ready_n update", 1'b0, ready_n)
            cq.push_back(b);
            host.frame(1'b0, 8, b);
            `CHK("ready_n after write", 1'b0, ready_n)
            rq.push_back(d);
            host.frame(1'b1, 24, 8'h00);
            rq.push_back(d);
            host.frame(1'b1, 24, 8'h00); // repeat read while flag high
            `CHK("ready_n repeat", 1'b1, ready_n)
            if (m == 4)
            begin
                // update inside the 560-cycle window must not drop the flag
                d = 24'($random(seed));
                result_data <= d;
                result_valid <= 1'b1;
                @(posedge clk);
                result_valid <= 1'b0;
                repeat (2) @(posedge clk);
                `CHK("ready_n deferred", 1'b1, ready_n)
            end
            // let every high window expire before the next setting
            repeat (600) @(posedge clk);
            `CHK("ready_n after hold", 1'(m != 4), ready_n)
        end
        conclude();
    end
    // watchdog well beyond the expected 8700 or so cycles
    initial
    begin
        repeat (20000) @(posedge clk);
        fail_count++;
        conclude();
    end
endmodule : test_serial_port_ready_timing
